// [inc/dpmi_defines.svh]
`ifndef DPMI_DEFINES_SVH
`define DPMI_DEFINES_SVH

// Number of media ports
`define DPMI_NPORTS 2
// Data nibble width on the media pins
`define DPMI_NIB_W 4
// Transmit FIFO shape: nibble plus end-of-frame flag
`define DPMI_FIFO_WIDTH 5
`define DPMI_FIFO_DEPTH 16
// Clock rates in MHz
`define DPMI_CLK_SYS_MHZ 50
`define DPMI_BASE_CLK_MHZ 25
`define DPMI_RMII_CLK_MHZ 50
// Base clock half period in core cycles
`define DPMI_BASE_HALF (`DPMI_CLK_SYS_MHZ / (2 * `DPMI_BASE_CLK_MHZ))
// Width of the base clock divider counter
`define DPMI_DIV_W 2

`endif

// [inc/dpmi_pkg.sv]
package dpmi_pkg;
`include "dpmi_defines.svh"

    // Transmit sequencer per port
    typedef enum logic [1:0] {
        DPMI_TX_IDLE,   // Ready to fetch the next nibble
        DPMI_TX_HIGH,   // Reduced mode: upper dibit still to send
        DPMI_TX_GAP     // One idle step after a frame end
    } dpmi_tx_st_t;

    // Two-stage level synchroniser
    typedef struct packed {
        logic stage1;   // Metastable stage, read by stage2 only
        logic stage2;   // Settled level
    } dpmi_sync_st_t;

    // Whole state of the media interface core
    typedef struct packed {
        logic [`DPMI_DIV_W-1:0]                         div_cnt;
        logic                                           base_clk;
        logic                                           rmii_clk_en;
        dpmi_tx_st_t [`DPMI_NPORTS-1:0]                 tx_st;
        logic [`DPMI_NPORTS-1:0]                        tx_last;
        logic [`DPMI_NPORTS-1:0][`DPMI_NIB_W-1:0]       tx_nib;
        logic [`DPMI_NPORTS-1:0][`DPMI_NIB_W-1:0]       tx_d;
        logic [`DPMI_NPORTS-1:0]                        tx_en;
        logic [`DPMI_NPORTS-1:0]                        txclk_q;
        logic [`DPMI_NPORTS-1:0]                        rxclk_q;
        logic [`DPMI_NPORTS-1:0]                        rx_dv_q;
        logic [`DPMI_NPORTS-1:0]                        rx_half;
        logic [`DPMI_NPORTS-1:0][1:0]                   rx_low;
        logic [`DPMI_NPORTS-1:0][`DPMI_NIB_W-1:0]       rx_d;
        logic [`DPMI_NPORTS-1:0]                        rx_v;
        logic [`DPMI_NPORTS-1:0]                        rx_end;
        logic [`DPMI_NPORTS-1:0]                        crs;
        logic [`DPMI_NPORTS-1:0]                        col;
        logic [`DPMI_NPORTS-1:0]                        led;
    } dpmi_core_st_t;

endpackage : dpmi_pkg

// [verilog/dpmi_sync2.sv]
`timescale 1ns/1ns
module dpmi_sync2
    import dpmi_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic async_in,
    output logic      sync_out
);
    dpmi_sync_st_t st_ff;   // Both stages
    dpmi_sync_st_t nxt_st;  // Next stages

    // Shift the level through two flops; stage1 feeds stage2 only
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.stage1 = async_in;
        nxt_st.stage2 = st_ff.stage1;
    end

    // Synchronous reset to a known low level
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_out = st_ff.stage2;

    sync_delay_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ($past(rst_n, 2) && $past(rst_n)) |-> sync_out == $past(async_in, 2))
        else $error("Synchroniser output is not input delayed by two");

endmodule : dpmi_sync2

// [verilog/dpmi_fifo.sv]
`timescale 1ns/1ns
module dpmi_fifo
    import dpmi_pkg::*;
#(
    parameter int WIDTH = `DPMI_FIFO_WIDTH,
    parameter int DEPTH = `DPMI_FIFO_DEPTH
)(
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    // Storage, pointers, fill level and registered flags
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [CW-1:0]               count;
        logic                        room;   // Not full
        logic                        avail;  // Not empty
    } dpmi_fifo_st_t;

    dpmi_fifo_st_t st_ff;   // Current state
    dpmi_fifo_st_t nxt_st;  // Next state
    logic          push;    // Word accepted this cycle
    logic          pop;     // Word drained this cycle

    // Flags are registered so that both ready and valid come from flops
    always_comb begin
        nxt_st = st_ff;
        push   = in_valid & st_ff.room;
        pop    = out_ready & st_ff.avail;
        if (push) begin
            nxt_st.mem[st_ff.wr_ptr] = in_data;
            nxt_st.wr_ptr            = AW'(st_ff.wr_ptr + 1'b1);
        end
        if (pop) begin
            nxt_st.rd_ptr = AW'(st_ff.rd_ptr + 1'b1);
        end
        // Simultaneous push and pop leave the level unchanged
        nxt_st.count = CW'(st_ff.count + {{(CW-1){1'b0}}, push}
                           - {{(CW-1){1'b0}}, pop});
        nxt_st.room  = (nxt_st.count != FULL_CNT);
        nxt_st.avail = (nxt_st.count != '0);
    end

    // Synchronous reset empties the buffer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign in_ready  = st_ff.room;
    assign out_valid = st_ff.avail;
    assign out_data  = st_ff.mem[st_ff.rd_ptr];

    fifo_fill_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (push && !pop) |=> out_valid)
        else $error("Pushed word did not make the buffer non-empty");

    fifo_full_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st_ff.count == FULL_CNT) |-> !in_ready && st_ff.wr_ptr == st_ff.rd_ptr)
        else $error("Full buffer shows ready or pointers disagree");

endmodule : dpmi_fifo

// [verilog/dpmi_media_if.sv]
`timescale 1ns/1ns
module dpmi_media_if
    import dpmi_pkg::*;
(
    input  wire logic                                     clk_sys,
    input  wire logic                                     rst_n,
    input  wire logic [`DPMI_NPORTS-1:0]                  port_rmii_mode,
    output logic                                          rmii_ref_clock_out_en,
    output logic                                          phy_base_clock_out,
    input  wire logic [`DPMI_NPORTS-1:0]                  port_link_up_in,
    output logic      [`DPMI_NPORTS-1:0]                  port_activity_led_out,
    input  wire logic                                     port1_tx_clock_in,
    input  wire logic                                     port2_tx_clock_in,
    input  wire logic                                     port1_rx_clock_in,
    input  wire logic                                     port2_rx_clock_in,
    output logic      [`DPMI_NIB_W-1:0]                   port1_tx_data,
    output logic      [`DPMI_NIB_W-1:0]                   port2_tx_data,
    output logic                                          port1_tx_enable,
    output logic                                          port2_tx_enable,
    input  wire logic [`DPMI_NIB_W-1:0]                   port1_rx_data,
    input  wire logic [`DPMI_NIB_W-1:0]                   port2_rx_data,
    input  wire logic                                     port1_rx_valid,
    input  wire logic                                     port2_rx_valid,
    input  wire logic                                     port1_carrier_sense,
    input  wire logic                                     port2_carrier_sense,
    input  wire logic                                     port1_collision,
    input  wire logic                                     port2_collision,
    input  wire logic [`DPMI_NPORTS-1:0][`DPMI_NIB_W-1:0] tx_in_data,
    input  wire logic [`DPMI_NPORTS-1:0]                  tx_in_last,
    input  wire logic [`DPMI_NPORTS-1:0]                  tx_in_valid,
    output logic      [`DPMI_NPORTS-1:0]                  tx_in_ready,
    output logic      [`DPMI_NPORTS-1:0][`DPMI_NIB_W-1:0] rx_out_data,
    output logic      [`DPMI_NPORTS-1:0]                  rx_out_valid,
    output logic      [`DPMI_NPORTS-1:0]                  rx_out_end,
    output logic      [`DPMI_NPORTS-1:0]                  port_carrier_out,
    output logic      [`DPMI_NPORTS-1:0]                  port_collision_out
);
    localparam int N = `DPMI_NPORTS;
    localparam int FW = `DPMI_FIFO_WIDTH;
    localparam logic [`DPMI_DIV_W-1:0] BASE_LAST = `DPMI_DIV_W'(`DPMI_BASE_HALF - 1);

    dpmi_core_st_t          st_ff;     // Current core state
    dpmi_core_st_t          nxt_st;    // Next core state
    logic [N-1:0]           link;      // Synchronised link level
    logic [N-1:0]           txclk;     // PHY transmit clocks as samples
    logic [N-1:0]           rxclk;     // PHY receive clocks as samples
    logic [N-1:0]           rxdv;      // Receive data valid pins
    logic [N-1:0]           crs_in;    // Carrier sense pins
    logic [N-1:0]           col_in;    // Collision pins
    logic [N-1:0][3:0]      rxd;       // Receive data pins
    logic [N-1:0][FW-1:0]   fifo_dout; // Head word: {last, nibble}
    logic [N-1:0]           fifo_vld;  // Head word present
    logic [N-1:0]           pop;       // Take head word now
    logic [N-1:0]           tx_stb;    // Transmit timing step
    logic [N-1:0]           rx_stb;    // Receive timing step

    // Gather the per-port pins into indexed vectors
    assign txclk  = {port2_tx_clock_in, port1_tx_clock_in};
    assign rxclk  = {port2_rx_clock_in, port1_rx_clock_in};
    assign rxdv   = {port2_rx_valid, port1_rx_valid};
    assign crs_in = {port2_carrier_sense, port1_carrier_sense};
    assign col_in = {port2_collision, port1_collision};
    assign rxd    = {port2_rx_data, port1_rx_data};

    // Per-port link synchroniser and transmit buffer
    for (genvar g = 0; g < N; g++) begin : g_port
        // Link pin is asynchronous to the core; never read it raw
        dpmi_sync2 u_link_sync (
            .clk_sys  (clk_sys),
            .rst_n    (rst_n),
            .async_in (port_link_up_in[g]),
            .sync_out (link[g])
        );

        // Buffer absorbs bursts; ready drops when 16 nibbles wait
        dpmi_fifo #(
            .WIDTH (FW),
            .DEPTH (`DPMI_FIFO_DEPTH)
        ) u_tx_fifo (
            .clk_sys   (clk_sys),
            .rst_n     (rst_n),
            .in_data   ({tx_in_last[g], tx_in_data[g]}),
            .in_valid  (tx_in_valid[g]),
            .in_ready  (tx_in_ready[g]),
            .out_data  (fifo_dout[g]),
            .out_valid (fifo_vld[g]),
            .out_ready (pop[g])
        );
    end

    // Core next-state logic for clocks and both ports
    always_comb begin
        nxt_st = st_ff;
        pop    = '0;
        tx_stb = '0;
        rx_stb = '0;

        // 25 MHz base clock by dividing the 50 MHz core clock
        if (st_ff.div_cnt == BASE_LAST) begin
            nxt_st.div_cnt  = '0;
            nxt_st.base_clk = ~st_ff.base_clk;
        end else begin
            nxt_st.div_cnt = `DPMI_DIV_W'(st_ff.div_cnt + 1'b1);
        end

        // The core clock is the PLL's 50 MHz; one enable forwards it
        // to the single reference pin shared by both ports
        nxt_st.rmii_clk_en = |port_rmii_mode;

        for (int p = 0; p < N; p++) begin
            // Reduced mode steps every core cycle; full mode steps on
            // each rising edge of the PHY-made clock
            nxt_st.txclk_q[p] = txclk[p];
            nxt_st.rxclk_q[p] = rxclk[p];
            tx_stb[p] = port_rmii_mode[p] | (txclk[p] & ~st_ff.txclk_q[p]);
            rx_stb[p] = port_rmii_mode[p] | (rxclk[p] & ~st_ff.rxclk_q[p]);

            // Transmit: link down kills the frame at once
            if (!link[p]) begin
                nxt_st.tx_st[p] = DPMI_TX_IDLE;
                nxt_st.tx_en[p] = 1'b0;
                nxt_st.tx_d[p]  = '0;
            end else if (tx_stb[p]) begin
                unique case (st_ff.tx_st[p])
                    DPMI_TX_IDLE: begin
                        if (fifo_vld[p]) begin
                            pop[p]            = 1'b1;
                            nxt_st.tx_nib[p]  = fifo_dout[p][3:0];
                            nxt_st.tx_last[p] = fifo_dout[p][FW-1];
                            nxt_st.tx_en[p]   = 1'b1;
                            if (port_rmii_mode[p]) begin
                                // Low dibit first, upper pins held low
                                nxt_st.tx_d[p]  = {2'b00, fifo_dout[p][1:0]};
                                nxt_st.tx_st[p] = DPMI_TX_HIGH;
                            end else begin
                                // Full nibble per transmit clock
                                nxt_st.tx_d[p]  = fifo_dout[p][3:0];
                                nxt_st.tx_st[p] = fifo_dout[p][FW-1] ? DPMI_TX_GAP
                                                                     : DPMI_TX_IDLE;
                            end
                        end else begin
                            // Underrun ends the enable; nothing to show
                            nxt_st.tx_en[p] = 1'b0;
                            nxt_st.tx_d[p]  = '0;
                        end
                    end
                    DPMI_TX_HIGH: begin
                        // Upper dibit of the held nibble
                        nxt_st.tx_d[p]  = {2'b00, st_ff.tx_nib[p][3:2]};
                        nxt_st.tx_en[p] = 1'b1;
                        nxt_st.tx_st[p] = st_ff.tx_last[p] ? DPMI_TX_GAP : DPMI_TX_IDLE;
                    end
                    DPMI_TX_GAP: begin
                        // One step with enable low splits frames
                        nxt_st.tx_en[p] = 1'b0;
                        nxt_st.tx_d[p]  = '0;
                        nxt_st.tx_st[p] = DPMI_TX_IDLE;
                    end
                    default: begin
                        // Unused code: recover quietly
                        nxt_st.tx_en[p] = 1'b0;
                        nxt_st.tx_d[p]  = '0;
                        nxt_st.tx_st[p] = DPMI_TX_IDLE;
                    end
                endcase
            end

            // Receive pulses last one cycle
            nxt_st.rx_v[p]   = 1'b0;
            nxt_st.rx_end[p] = 1'b0;
            if (rx_stb[p]) begin
                nxt_st.rx_dv_q[p] = rxdv[p];
                if (rxdv[p]) begin
                    if (port_rmii_mode[p]) begin
                        // Two dibits on bits 0 and 1 build one nibble
                        if (!st_ff.rx_half[p]) begin
                            nxt_st.rx_low[p]  = rxd[p][1:0];
                            nxt_st.rx_half[p] = 1'b1;
                        end else begin
                            nxt_st.rx_d[p]    = {rxd[p][1:0], st_ff.rx_low[p]};
                            nxt_st.rx_v[p]    = 1'b1;
                            nxt_st.rx_half[p] = 1'b0;
                        end
                    end else begin
                        nxt_st.rx_d[p] = rxd[p];
                        nxt_st.rx_v[p] = 1'b1;
                    end
                end else begin
                    // Stray half nibble at frame end is dropped
                    nxt_st.rx_half[p] = 1'b0;
                    nxt_st.rx_end[p]  = st_ff.rx_dv_q[p];
                end
            end

            // Medium state; collision has no pin in reduced mode
            nxt_st.crs[p] = crs_in[p];
            nxt_st.col[p] = col_in[p] & ~port_rmii_mode[p];
            // Steady level, so no blink filtering is needed
            nxt_st.led[p] = link[p];
        end
    end

    // Register the whole core state, synchronous active-low reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Every output straight from a flop
    assign rmii_ref_clock_out_en = st_ff.rmii_clk_en;
    assign phy_base_clock_out    = st_ff.base_clk;
    assign port_activity_led_out = st_ff.led;
    assign port1_tx_data         = st_ff.tx_d[0];
    assign port2_tx_data         = st_ff.tx_d[1];
    assign port1_tx_enable       = st_ff.tx_en[0];
    assign port2_tx_enable       = st_ff.tx_en[1];
    assign rx_out_data           = st_ff.rx_d;
    assign rx_out_valid          = st_ff.rx_v;
    assign rx_out_end            = st_ff.rx_end;
    assign port_carrier_out      = st_ff.crs;
    assign port_collision_out    = st_ff.col;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    base_clk_toggle_a: assert property ($past(rst_n) |->
        phy_base_clock_out != $past(phy_base_clock_out))
        else $error("Base clock did not toggle every core cycle");

    rmii_clk_en_a: assert property ($past(rst_n) |->
        rmii_ref_clock_out_en == $past(|port_rmii_mode))
        else $error("Reference clock enable does not follow mode");

    for (genvar q = 0; q < N; q++) begin : g_chk
        sequence mii_rx_edge;
            !port_rmii_mode[q] && rxclk[q] && !st_ff.rxclk_q[q] && rxdv[q];
        endsequence

        sequence link_steady;
            port_link_up_in[q] [*4];
        endsequence

        link_gate_tx_a: assert property (!link[q] |=> !st_ff.tx_en[q])
            else $error("Transmit enable raised while link down");

        led_follow_a: assert property (link_steady |-> port_activity_led_out[q])
            else $error("Activity output low after steady link up");

        rmii_upper_a: assert property ($past(port_rmii_mode[q])
            |-> st_ff.tx_d[q][3:2] == 2'h0)
            else $error("Upper transmit bits driven in reduced mode");

        pop_shows_a: assert property (pop[q] |=> st_ff.tx_en[q])
            else $error("Fetched nibble not shown with enable");

        mii_rx_take_a: assert property (mii_rx_edge |=>
            rx_out_valid[q] && rx_out_data[q] == $past(rxd[q]))
            else $error("Receive nibble not taken on PHY clock edge");

        rx_needs_dv_a: assert property (rx_out_valid[q] |-> $past(rxdv[q]))
            else $error("Receive nibble emitted without data valid");

        col_mask_a: assert property ($past(port_rmii_mode[q])
            |-> !port_collision_out[q])
            else $error("Collision reported in reduced mode");
    end

endmodule : dpmi_media_if

// [verification/dpmi_phy_model.sv]
`timescale 1ns/1ns
// Behavioural PHY for one port
module dpmi_phy_model (
    input  wire logic       clk_sys,
    input  wire logic       base_clk,
    output logic            tx_clock,
    output logic            rx_clock,
    output logic [3:0]      rx_data,
    output logic            rx_valid
);
    // Port clocks are built from the base clock, no local oscillator
    assign #2 tx_clock = base_clk;
    assign #2 rx_clock = base_clk;
    // No management pins here: the host sets up the PHY
    // Idle at time zero
    initial begin
        rx_data  = 4'h0;
        rx_valid = 1'b0;
    end
    // One nibble framed by valid; idle data is inverted so stale bits never match
    task automatic send(input logic [3:0] nib, input logic rmii);
        @(posedge clk_sys);
        #1;
        if (rmii) begin
            // Upper pins carry junk in reduced mode
            rx_valid = 1'b1;
            rx_data  = {2'b11, nib[1:0]};
            @(posedge clk_sys);
            #1;
            rx_data  = {2'b11, nib[3:2]};
        end else begin
            // Change data only while the receive clock is low; any two
            // core edges hold exactly one rising clock sample
            if (rx_clock) begin
                @(posedge clk_sys);
                #1;
            end
            rx_valid = 1'b1;
            rx_data  = nib;
            @(posedge clk_sys);
            #1;
        end
        @(posedge clk_sys);
        #1;
        rx_valid = 1'b0;
        rx_data  = ~rx_data;
    endtask : send
endmodule : dpmi_phy_model

// [verification/testbench.sv]
`timescale 1ns/1ns
module testbench;
    import dpmi_pkg::*;
    // Table row: inputs, then the outputs they should give
    typedef struct packed {
        logic [1:0] mode, link, crs, col;
        logic       en;
        logic [1:0] led, crs_o, col_o;
    } dpmi_row_t;
    logic            clk_sys, rst_n, rmii_ref_clock_out_en, phy_base_clock_out, b;
    logic [1:0]      port_rmii_mode, port_link_up_in, port_activity_led_out;
    logic            port1_tx_clock_in, port2_tx_clock_in, port1_rx_clock_in, port2_rx_clock_in;
    logic [3:0]      port1_tx_data, port2_tx_data, port1_rx_data, port2_rx_data;
    logic            port1_tx_enable, port2_tx_enable, port1_rx_valid, port2_rx_valid;
    logic            port1_carrier_sense, port2_carrier_sense, port1_collision, port2_collision;
    logic [1:0][3:0] tx_in_data, rx_out_data;
    logic [1:0]      tx_in_last, tx_in_valid, tx_in_ready, rx_out_valid, rx_out_end;
    logic [1:0]      port_carrier_out, port_collision_out;
    int              fails, num_checks, n;
    dpmi_row_t       rows [4];

    dpmi_media_if i_dpmi_media_if (.*);
    dpmi_phy_model i_phy1 (.clk_sys(clk_sys), .base_clk(phy_base_clock_out),
        .tx_clock(port1_tx_clock_in), .rx_clock(port1_rx_clock_in),
        .rx_data(port1_rx_data), .rx_valid(port1_rx_valid));
    dpmi_phy_model i_phy2 (.clk_sys(clk_sys), .base_clk(phy_base_clock_out),
        .tx_clock(port2_tx_clock_in), .rx_clock(port2_rx_clock_in),
        .rx_data(port2_rx_data), .rx_valid(port2_rx_valid));

    // Core clock, 20 ns period
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Count and report one comparison
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // Verdict and end of run
    task automatic results();
        if (fails == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    // Step n edges, then settle
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : tick
    // Condition selector for bounded waits
    function automatic logic probe(input int k, input int p);
        logic [1:0] txe;
        txe = {port2_tx_enable, port1_tx_enable};
        case (k)
            0: return rx_out_valid[p];
            1: return rx_out_end[p];
            2: return txe[p];
            3: return !txe[p];
            default: return tx_in_ready[p];
        endcase
    endfunction : probe
    // Bounded wait; running out counts as a mismatch and closes the run
    task automatic wait_on(input int k, input int p);
        int w;
        w = 0;
        while (probe(k, p) !== 1'b1) begin
            if (w == 200) begin
                chk("wait bound", 8'h00, 8'h01);
                results();
            end
            tick(1);
            w++;
        end
    endtask : wait_on
    // Hand one nibble to the transmit stream, held until taken
    task automatic push(input int p, input logic [3:0] nib, input logic last);
        tx_in_data[p]  = nib;
        tx_in_last[p]  = last;
        tx_in_valid[p] = 1'b1;
        wait_on(4, p);
        tick(1);
        tx_in_valid[p] = 1'b0;
        // Let an edge pass so a following push never re-raises valid in this step
        tick(1);
    endtask : push
    // PHY sends one nibble while the bench watches the user side
    task automatic rx_case(input int p, input logic [3:0] nib, input logic rmii);
        fork
            if (p == 0) begin
                i_phy1.send(nib, rmii);
            end else begin
                i_phy2.send(nib, rmii);
            end
            begin
                wait_on(0, p);
                chk("rx nibble", {4'h0, nib}, {4'h0, rx_out_data[p]});
                wait_on(1, p);
            end
        join
    endtask : rx_case

    // Main sequence
    initial begin
        fails = 0;
        num_checks = 0;
        rst_n = 1'b0;
        port_rmii_mode = 2'h0;
        port_link_up_in = 2'h0;
        {port2_carrier_sense, port1_carrier_sense, port2_collision, port1_collision} = 4'h0;
        tx_in_data = 8'h00;
        tx_in_last = 2'h0;
        tx_in_valid = 2'h0;
        rows[0] = {2'h0, 2'h3, 2'h3, 2'h3, 1'b0, 2'h3, 2'h3, 2'h3};
        rows[1] = {2'h1, 2'h1, 2'h2, 2'h3, 1'b1, 2'h1, 2'h2, 2'h2};
        rows[2] = {2'h2, 2'h2, 2'h1, 2'h1, 1'b1, 2'h2, 2'h1, 2'h1};
        rows[3] = {2'h3, 2'h0, 2'h0, 2'h3, 1'b1, 2'h0, 2'h0, 2'h0};
        tick(11);
        chk("reset outputs", 8'h00, {port_activity_led_out, tx_in_ready, rx_out_valid,
            port1_tx_enable, phy_base_clock_out});
        tick(1);
        rst_n = 1'b1;
        tick(1);
        chk("ready after reset", 8'h03, {6'h00, tx_in_ready});
        b = phy_base_clock_out;
        tick(1);
        chk("base clock toggle", {7'h00, ~b}, {7'h00, phy_base_clock_out});
        // Link inputs are held as steady levels
        foreach (rows[i]) begin
            port_rmii_mode = rows[i].mode;
            port_link_up_in = rows[i].link;
            {port2_carrier_sense, port1_carrier_sense} = rows[i].crs;
            {port2_collision, port1_collision} = rows[i].col;
            tick(5);
            chk("ref enable", {7'h00, rows[i].en},
                {7'h00, rmii_ref_clock_out_en});
            chk("led", {6'h00, rows[i].led},
                {6'h00, port_activity_led_out});
            chk("carrier", {6'h00, rows[i].crs_o}, {6'h00, port_carrier_out});
            chk("collision", {6'h00, rows[i].col_o},
                {6'h00, port_collision_out});
        end
        // Two frames queued while the link is down, then released
        port_rmii_mode = 2'h1;
        port_link_up_in = 2'h0;
        tick(5);
        push(0, 4'ha, 1'b1);
        push(0, 4'h5, 1'b1);
        tick(4);
        chk("tx blocked", 8'h00, {7'h00, port1_tx_enable});
        port_link_up_in = 2'h3;
        wait_on(2, 0);
        chk("tx low dibit", 8'h02, {4'h0, port1_tx_data});
        tick(1);
        chk("tx high dibit", 8'h02, {4'h0, port1_tx_data});
        tick(1);
        chk("tx gap", 8'h00, {7'h00, port1_tx_enable});
        wait_on(2, 0);
        chk("tx second low", 8'h01, {4'h0, port1_tx_data});
        tick(1);
        chk("tx second high", 8'h01, {4'h0, port1_tx_data});
        push(1, 4'h6, 1'b1);
        wait_on(2, 1);
        chk("mii tx nibble", 8'h06, {4'h0, port2_tx_data});
        rx_case(1, 4'hc, 1'b0);
        rx_case(0, 4'h9, 1'b1);
        // Fill the port 2 buffer while its link is down, then drain it
        port_link_up_in = 2'h1;
        tick(5);
        n = 0;
        tx_in_valid[1] = 1'b1;
        while (tx_in_ready[1] === 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        tx_in_valid[1] = 1'b0;
        chk("fifo depth", 8'h10, n[7:0]);
        chk("tx stalled", 8'h00, {7'h00, port2_tx_enable});
        port_link_up_in = 2'h3;
        for (int k = 0; k < 16; k++) begin
            wait_on(2, 1);
            wait_on(3, 1);
        end
        tick(10);
        chk("drained", 8'h02, {6'h00, tx_in_ready[1], port2_tx_enable});
        results();
    end
endmodule : testbench
